// ---- ddr3_phy_pkg.sv ----
package ddr3_phy_pkg;

    // timing
    localparam int CLK_PERIOD_PS   = 8000;
    localparam int SOFT_RST_NS     = 128;
    localparam int SOFT_RST_CYCLES = (SOFT_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SOFT_CNT_W      = 5;
    localparam int BURST_CYCLES    = 4;
    localparam int GATE_CNT_W      = 3;
    localparam int RD_SHIFT_W      = 18;
    localparam int DELAY_W         = 5;
    localparam int BUF_LAG         = 4;

    // register map
    localparam int          REG_ADDR_W = 4;
    localparam logic [3:0]  CTRL_OFS   = 4'h0;
    localparam logic [3:0]  STATUS_OFS = 4'h4;

    // command bus carried for parity
    localparam int ROW_W = 14;
    localparam int BA_W  = 3;

    typedef struct packed {
        logic [ROW_W-1:0] addr;
        logic [BA_W-1:0]  ba;
        logic             ras_n;
        logic             cas_n;
        logic             we_n;
    } cmd_t;

    // control register, bit 0 is post_cycle[0]
    typedef struct packed {
        logic       parity_en;
        logic       cal_done;
        logic       align_odd;
        logic       realign_late;
        logic [2:0] chain;
        logic [1:0] phase;
        logic [2:0] post_cycle;
    } ctrl_t;

    localparam int    CTRL_W     = 12;
    localparam ctrl_t CTRL_RESET = ctrl_t'(12'h800);

    // status register, bit 0 is parity_fault
    typedef struct packed {
        logic [7:0] drift;
        logic       core_rst;
        logic       pll_locked;
        logic       parity_fault;
    } status_t;

    localparam int STATUS_W = 11;

endpackage : ddr3_phy_pkg

// ---- demux_buffer.sv ----
module demux_buffer
    import ddr3_phy_pkg::*;
#(
    parameter int W       = 16,
    parameter int DEPTH_W = 3
) (
    // clock and reset
    input  wire logic           ref_clk_i,
    input  wire logic           rst_i,
    // narrow write side, every cycle
    input  wire logic [W-1:0]   wr_data_i,
    input  wire logic           wr_valid_i,
    // wide read side, half-rate enable
    input  wire logic           rd_en_i,
    input  wire logic           align_i,
    output logic      [2*W-1:0] rd_data_o,
    output logic                rd_valid_o
);

    logic [W:0]         mem [2**DEPTH_W];
    logic [DEPTH_W-1:0] wr_ptr;
    logic [DEPTH_W-1:0] next_wr_ptr;
    logic [DEPTH_W-1:0] rd_base;
    logic [DEPTH_W-1:0] rd_next;
    logic [2*W-1:0]     next_rd_data;
    logic               next_rd_valid;

    // pointers never stop, so output trails input by a fixed lag
    always_comb begin
        next_wr_ptr   = rst_i ? '0 : wr_ptr + 1'b1;
        rd_base       = wr_ptr - DEPTH_W'(BUF_LAG) + DEPTH_W'(align_i);
        rd_next       = rd_base + 1'b1;
        next_rd_data  = rd_data_o;
        next_rd_valid = rd_valid_o;
        if (rst_i) begin
            next_rd_data  = '0;
            next_rd_valid = 1'b0;
        end else if (rd_en_i) begin
            next_rd_data  = {mem[rd_next][W-1:0], mem[rd_base][W-1:0]};
            next_rd_valid = mem[rd_next][W] & mem[rd_base][W];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        wr_ptr         <= next_wr_ptr;
        mem[wr_ptr]    <= rst_i ? '0 : {wr_valid_i, wr_data_i};
        rd_data_o      <= next_rd_data;
        rd_valid_o     <= next_rd_valid;
    end

endmodule : demux_buffer

// ---- ddr3_phy_read_path_reset.sv ----
// Overview of operation
// - a free-running full-rate tracking clock measures drift against the mimic feedback
// - half-rate enable runs at half, full-rate logic at memory clock rate
// - the clock divider has its own reset synchroniser without soft reset
// - read data captured by strobe, then retimed at a calibrated realign phase
// - n-bit double-rate data becomes 2n-bit, then 4n-bit at half rate
// - dual-port buffer with free-running pointers gives constant latency
// - sequencer alignment puts one transfer within one half-rate cycle
// - postamble gate closes strobe capture at the end of each read
// - gate cycle, phase and delay come from calibration before use
// - memory reset output follows internal reset of global, soft and lock
// - one parity bit over address and command is driven to the DIMM
// - parity fault flag goes low on error and holds until reset
// - low global reset resets the PLL and all logic by level
// - soft reset falling edge resets the core logic but leaves the PLL and the clock divider
// - reset request output follows PLL lock directly, low while locking
// - memory clock pins are driven out and their input fed back
// - the soft reset edge detector runs on the reference clock domain
module ddr3_phy_read_path_reset
    import ddr3_phy_pkg::*;
#(
    parameter int DQ_W = 8
) (
    // clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_i,
    // reset management
    input  wire logic                  global_reset_n_i,
    input  wire logic                  soft_reset_n_i,
    input  wire logic                  pll_locked_i,
    output logic                       pll_reset_o,
    output logic                       reset_request_n_o,
    output logic                       core_reset_n_o,
    output logic                       mem_reset_n_o,
    // clocks
    output logic                       half_rate_en_o,
    output logic                       drift_tracking_clock_o,
    output logic                       mem_clk_o,
    output logic                       mem_clk_n_o,
    output logic                       mem_clk_oe_o,
    input  wire logic                  mem_clk_i,
    // command parity
    input  wire cmd_t                  cmd_i,
    output logic                       command_parity_out_o,
    input  wire logic                  mem_err_out_n_i,
    output logic                       parity_fault_n_o,
    // read path
    input  wire logic                  doing_read_i,
    input  wire logic [DQ_W-1:0]       dq_rise_i,
    input  wire logic [DQ_W-1:0]       dq_fall_i,
    input  wire logic                  dqs_i,
    output logic                       postamble_gate_o,
    output logic      [4*DQ_W-1:0]     rdata_o,
    output logic                       rdata_valid_o,
    // register port
    input  wire logic [REG_ADDR_W-1:0] reg_addr_i,
    input  wire logic [31:0]           reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [31:0]           reg_rdata_o
);

    // ---------------- reset management ----------------
    logic                  global_rst;
    logic                  soft_edge;
    logic                  core_src;
    logic                  div_rst;
    logic                  core_rst;
    logic                  soft_q;
    logic                  next_soft_q;
    logic [SOFT_CNT_W-1:0] soft_cnt;
    logic [SOFT_CNT_W-1:0] next_soft_cnt;
    logic [1:0]            div_sync;
    logic [1:0]            next_div_sync;
    logic [1:0]            core_sync;
    logic [1:0]            next_core_sync;
    logic                  mem_rst_n;
    logic                  next_mem_rst_n;

    assign global_rst = rst_i | ~global_reset_n_i;
    assign soft_edge  = soft_q & ~soft_reset_n_i;
    assign core_src   = global_rst | soft_edge | (soft_cnt != '0)
                      | ~pll_locked_i;
    // divider ignores soft reset so clocks keep running through it
    assign div_rst    = global_rst | div_sync[1];
    assign core_rst   = core_src | core_sync[1];

    always_comb begin
        next_soft_q    = global_rst ? 1'b1 : soft_reset_n_i;
        next_soft_cnt  = soft_cnt;
        if (global_rst) begin
            next_soft_cnt = '0;
        end else if (soft_edge) begin
            next_soft_cnt = SOFT_CNT_W'(SOFT_RST_CYCLES);
        end else if (soft_cnt != '0) begin
            next_soft_cnt = soft_cnt - 1'b1;
        end
        next_div_sync  = global_rst ? 2'b11 : {div_sync[0], 1'b0};
        next_core_sync = core_src ? 2'b11 : {core_sync[0], 1'b0};
        next_mem_rst_n = ~core_rst;
    end

    always_ff @(posedge ref_clk_i) begin
        soft_q    <= next_soft_q;
        soft_cnt  <= next_soft_cnt;
        div_sync  <= next_div_sync;
        core_sync <= next_core_sync;
        mem_rst_n <= next_mem_rst_n;
    end

    assign pll_reset_o       = global_rst;
    assign reset_request_n_o = pll_locked_i;
    assign core_reset_n_o    = ~core_rst;
    assign mem_reset_n_o     = mem_rst_n;

    // ---------------- clocks and drift tracking ----------------
    logic       half_en;
    logic       next_half_en;
    logic       track_clk;
    logic       next_track_clk;
    logic       mclk;
    logic       next_mclk;
    logic       mclk_d;
    logic       next_mclk_d;
    logic       mclk_oe;
    logic       next_mclk_oe;
    logic [7:0] drift;
    logic [7:0] next_drift;

    always_comb begin
        next_half_en   = ~half_en;
        next_track_clk = ~track_clk;
        next_mclk      = ~mclk;
        next_mclk_d    = mclk;
        next_mclk_oe   = 1'b1;
        next_drift     = drift;
        // feedback that disagrees with what was driven counts as drift
        if (mclk_oe && (mem_clk_i != mclk_d) && (drift != 8'hff)) begin
            next_drift = drift + 8'h01;
        end
        // divider reset overrides everything above, pin released meanwhile
        if (div_rst) begin
            next_half_en   = 1'b0;
            next_track_clk = 1'b0;
            next_mclk      = 1'b0;
            next_mclk_d    = 1'b0;
            next_mclk_oe   = 1'b0;
            next_drift     = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        half_en   <= next_half_en;
        track_clk <= next_track_clk;
        mclk      <= next_mclk;
        mclk_d    <= next_mclk_d;
        mclk_oe   <= next_mclk_oe;
        drift     <= next_drift;
    end

    assign half_rate_en_o         = half_en;
    assign drift_tracking_clock_o = track_clk;
    assign mem_clk_o              = mclk;
    assign mem_clk_n_o            = ~mclk;
    assign mem_clk_oe_o           = mclk_oe;

    // ---------------- register port ----------------
    ctrl_t       ctrl;
    ctrl_t       next_ctrl;
    status_t     status;
    logic [31:0] next_rdata;
    logic        fault;

    always_comb begin
        status.drift        = drift;
        status.core_rst     = core_rst;
        status.pll_locked   = pll_locked_i;
        status.parity_fault = fault;
        next_ctrl           = ctrl;
        next_rdata          = '0;
        if (core_rst) begin
            next_ctrl = CTRL_RESET;
        end else if (reg_wr_i && reg_addr_i == CTRL_OFS) begin
            next_ctrl = ctrl_t'(reg_wdata_i[CTRL_W-1:0]);
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                CTRL_OFS:   next_rdata = {{(32-CTRL_W){1'b0}}, ctrl};
                STATUS_OFS: next_rdata = {{(32-STATUS_W){1'b0}}, status};
                default:    next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        ctrl        <= next_ctrl;
        reg_rdata_o <= next_rdata;
    end

    // ---------------- command parity ----------------
    logic parity;
    logic next_parity;
    logic next_fault;

    always_comb begin
        next_parity = ctrl.parity_en & (^cmd_i);
        // sticky until the core is reset, a new error cannot be lost
        next_fault  = fault | ~mem_err_out_n_i;
        if (core_rst) begin
            next_parity = 1'b0;
            next_fault  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        parity <= next_parity;
        fault  <= next_fault;
    end

    assign command_parity_out_o = parity;
    assign parity_fault_n_o     = ~fault;

    // ---------------- read path ----------------
    logic [RD_SHIFT_W-1:0] rd_shift;
    logic [RD_SHIFT_W-1:0] next_rd_shift;
    logic [DELAY_W-1:0]    gate_delay;
    logic                  gate_start;
    logic [GATE_CNT_W-1:0] gate_cnt;
    logic [GATE_CNT_W-1:0] next_gate_cnt;
    logic                  gate_ok;
    logic [2*DQ_W-1:0]     cap_data;
    logic [2*DQ_W-1:0]     next_cap_data;
    logic                  cap_valid;
    logic                  next_cap_valid;
    logic [2*DQ_W:0]       stage1;
    logic [2*DQ_W:0]       next_stage1;
    logic [2*DQ_W:0]       stage2;
    logic [2*DQ_W:0]       next_stage2;
    logic [2*DQ_W:0]       realigned;

    // calibrated cycle, phase and delay chain together place the gate
    assign gate_delay = DELAY_W'(ctrl.post_cycle) + DELAY_W'(ctrl.phase)
                      + DELAY_W'(ctrl.chain);
    assign gate_start = rd_shift[gate_delay];
    // gating is only trusted once calibration has been declared done
    assign gate_ok    = (gate_cnt != '0) & ctrl.cal_done;

    always_comb begin
        next_rd_shift  = {rd_shift[RD_SHIFT_W-2:0], doing_read_i & half_en};
        next_gate_cnt  = gate_cnt;
        if (gate_start) begin
            next_gate_cnt = GATE_CNT_W'(BURST_CYCLES);
        end else if (gate_cnt != '0) begin
            next_gate_cnt = gate_cnt - 1'b1;
        end
        // strobe edges outside the gate, e.g. postamble glitches, are dropped
        next_cap_valid = gate_ok & dqs_i;
        next_cap_data  = next_cap_valid ? {dq_fall_i, dq_rise_i}
                                        : cap_data;
        next_stage1    = {cap_valid, cap_data};
        next_stage2    = stage1;
        if (core_rst) begin
            next_rd_shift  = '0;
            next_gate_cnt  = '0;
            next_cap_valid = 1'b0;
            next_cap_data  = '0;
            next_stage1    = '0;
            next_stage2    = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        rd_shift  <= next_rd_shift;
        gate_cnt  <= next_gate_cnt;
        cap_valid <= next_cap_valid;
        cap_data  <= next_cap_data;
        stage1    <= next_stage1;
        stage2    <= next_stage2;
    end

    // realign phase picked by calibration: early or one cycle late
    assign realigned        = ctrl.realign_late ? stage2 : stage1;
    assign postamble_gate_o = gate_ok;

    demux_buffer #(
        .W       (2 * DQ_W),
        .DEPTH_W (3)
    ) u_demux (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (core_rst),
        .wr_data_i  (realigned[2*DQ_W-1:0]),
        .wr_valid_i (realigned[2*DQ_W]),
        .rd_en_i    (half_en),
        .align_i    (ctrl.align_odd),
        .rd_data_o  (rdata_o),
        .rd_valid_o (rdata_valid_o)
    );

endmodule : ddr3_phy_read_path_reset

// ---- ddr3_phy_chk.sv ----
module ddr3_phy_chk
    import ddr3_phy_pkg::*;
(
    // clock and resets
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    input  wire logic global_reset_n_i,
    input  wire logic soft_reset_n_i,
    input  wire logic pll_locked_i,
    // reset and clock outputs
    input  wire logic pll_reset_o,
    input  wire logic reset_request_n_o,
    input  wire logic core_reset_n_o,
    input  wire logic mem_reset_n_o,
    input  wire logic half_rate_en_o,
    input  wire logic drift_tracking_clock_o,
    input  wire logic mem_clk_o,
    input  wire logic mem_clk_n_o,
    input  wire logic mem_clk_oe_o,
    // parity and read gate
    input  wire cmd_t cmd_i,
    input  wire logic command_parity_out_o,
    input  wire logic mem_err_out_n_i,
    input  wire logic parity_fault_n_o,
    input  wire logic postamble_gate_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence burst_open;
        postamble_gate_o [*4];
    endsequence
    sequence enter_reset;
        ##[0:2] !core_reset_n_o;
    endsequence
    sequence clocks_run;
        mem_clk_oe_o [*4];
    endsequence

    pll_rst_map_a: assert property (pll_reset_o == !global_reset_n_i)
        else $error("pll reset does not follow global reset");
    req_follow_a: assert property (reset_request_n_o == pll_locked_i)
        else $error("reset request does not follow lock");
    soft_enter_a: assert property ($fell(soft_reset_n_i) |-> enter_reset)
        else $error("soft reset edge missed");
    soft_keeps_clk_a: assert property ($fell(soft_reset_n_i) && mem_clk_oe_o && global_reset_n_i
        |=> clocks_run)
        else $error("soft reset stopped the clocks");
    lock_loss_a: assert property (!pll_locked_i |-> enter_reset)
        else $error("lock loss did not reset the core");
    mem_rst_a: assert property (!core_reset_n_o |=> !mem_reset_n_o)
        else $error("memory reset not driven from core reset");
    parity_out_a: assert property (core_reset_n_o && $past(core_reset_n_o)
        |-> command_parity_out_o == ^$past(cmd_i))
        else $error("command parity wrong");
    fault_set_a: assert property (!mem_err_out_n_i && core_reset_n_o |=> !parity_fault_n_o)
        else $error("parity fault not raised");
    fault_hold_a: assert property (!parity_fault_n_o && core_reset_n_o && global_reset_n_i
        && pll_locked_i && soft_reset_n_i |=> !parity_fault_n_o)
        else $error("parity fault dropped without reset");
    global_clear_a: assert property (!global_reset_n_i |=> parity_fault_n_o && !mem_clk_oe_o)
        else $error("global reset did not clear logic");
    half_rate_a: assert property (mem_clk_oe_o && $past(mem_clk_oe_o)
        |-> half_rate_en_o != $past(half_rate_en_o))
        else $error("half rate enable not alternating");
    drift_clk_a: assert property (mem_clk_oe_o && $past(mem_clk_oe_o)
        |-> drift_tracking_clock_o != $past(drift_tracking_clock_o))
        else $error("tracking clock not free running");
    mem_clk_pair_a: assert property (mem_clk_n_o == !mem_clk_o)
        else $error("memory clock pair not complementary");
    gate_len_a: assert property ($rose(postamble_gate_o) |-> burst_open)
        else $error("postamble gate shorter than a burst");
    sync_release_a: assert property ($rose(global_reset_n_i) && pll_locked_i && soft_reset_n_i
        |-> !core_reset_n_o [*2] ##[1:3] core_reset_n_o)
        else $error("core reset release not synchronised");
endmodule : ddr3_phy_chk

// ---- dimm_model.sv ----
module dimm_model
    import ddr3_phy_pkg::*;
(
    // clock and enables
    input  wire logic       ref_clk_i,
    input  wire logic       check_i,
    input  wire logic       inject_i,
    // command side from the device
    input  wire cmd_t       cmd_i,
    input  wire logic       parity_i,
    input  wire logic       gate_i,
    // towards the device
    output logic            err_n_o,
    output logic            dqs_o,
    output logic [7:0]      rise_o,
    output logic [7:0]      fall_o
);
    timeunit 1ns;
    timeprecision 1ps;
    cmd_t cmd_q = '0;
    logic junk  = 1'b0;
    initial err_n_o = 1'b1;
    always @(posedge ref_clk_i) begin
        cmd_q <= cmd_i;
        junk  <= ~junk;
        // low for the faulty cycle only, never held
        err_n_o <= ~(check_i && (inject_i || ((^cmd_q) != parity_i)));
    end
    // glitching strobe and junk data outside the gate, as a real bus after postamble
    assign dqs_o  = gate_i | junk;
    assign rise_o = gate_i ? 8'ha5 : {8{junk}};
    assign fall_o = gate_i ? 8'h3c : {8{~junk}};
endmodule : dimm_model

// ---- tb.sv ----
module tb
    import ddr3_phy_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [19:0] cmd; logic par; } row_t;
    localparam row_t ROWS [6] = '{'{20'h00000, 1'b0}, '{20'h00001, 1'b1}, '{20'h00003, 1'b0},
                                  '{20'hfffff, 1'b0}, '{20'h80000, 1'b1}, '{20'h7ffff, 1'b1}};
    logic ref_clk_i = 0, rst_i = 1, global_reset_n_i = 1, soft_reset_n_i = 1, pll_locked_i = 1;
    logic doing_read_i = 0, inject = 0, reg_wr_i = 0, reg_rd_i = 0, req_q = 1;
    cmd_t cmd_i = '0;
    logic [3:0] reg_addr_i = '0;
    logic [31:0] reg_wdata_i = '0, reg_rdata_o, rdata_o, d;
    logic pll_reset_o, reset_request_n_o, core_reset_n_o, mem_reset_n_o, half_rate_en_o;
    logic drift_tracking_clock_o, mem_clk_o, mem_clk_n_o, mem_clk_oe_o, mem_clk_i = 1'b0;
    logic command_parity_out_o, mem_err_out_n_i, parity_fault_n_o, dqs_i;
    logic postamble_gate_o, rdata_valid_o;
    logic [7:0] dq_rise_i, dq_fall_i;
    int fail_count = 0, tests_run = 0, hits, req_falls = 0;

    // pin loops back one cycle late; a released pin falls to its pull-down level
    always @(posedge ref_clk_i) mem_clk_i <= mem_clk_oe_o & mem_clk_o;
    // system reset logic acts on the falling edge of the request, not its level
    always @(posedge ref_clk_i) begin
        req_q <= reset_request_n_o;
        if (req_q && !reset_request_n_o) begin
            req_falls <= req_falls + 1;
        end
    end
    always #4 ref_clk_i = ~ref_clk_i;

    ddr3_phy_read_path_reset #(.DQ_W(8)) u_dut (.ref_clk_i, .rst_i, .global_reset_n_i,
        .soft_reset_n_i, .pll_locked_i, .pll_reset_o, .reset_request_n_o, .core_reset_n_o,
        .mem_reset_n_o, .half_rate_en_o, .drift_tracking_clock_o, .mem_clk_o, .mem_clk_n_o,
        .mem_clk_oe_o, .mem_clk_i, .cmd_i, .command_parity_out_o, .mem_err_out_n_i,
        .parity_fault_n_o, .doing_read_i, .dq_rise_i, .dq_fall_i, .dqs_i, .postamble_gate_o,
        .rdata_o, .rdata_valid_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
    dimm_model u_dimm (.ref_clk_i(ref_clk_i), .check_i(core_reset_n_o), .inject_i(inject),
        .cmd_i(cmd_i), .parity_i(command_parity_out_o), .gate_i(postamble_gate_o),
        .err_n_o(mem_err_out_n_i), .dqs_o(dqs_i), .rise_o(dq_rise_i), .fall_o(dq_fall_i));

    task automatic close_out();
        $display("checks run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : step
    task automatic wait_core();
        int n;
        n = 0;
        while (core_reset_n_o !== 1'b1 && n < 60) begin
            step(1);
            n++;
        end
        if (core_reset_n_o !== 1'b1) begin
            chk(core_reset_n_o, 1'b1, "core reset release");
            close_out();
        end
    endtask : wait_core
    task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask : reg_read
    task automatic rd_burst(output int n, output logic [31:0] word);
        n = 0;
        word = '0;
        @(posedge ref_clk_i);
        doing_read_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        doing_read_i <= 1'b0;
        repeat (60) begin
            step(1);
            // a word stands for one half-rate cycle, count it once
            if (rdata_valid_o === 1'b1 && half_rate_en_o === 1'b1) begin
                n++;
                word = rdata_o;
            end
        end
    endtask : rd_burst

    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        wait_core();
        foreach (ROWS[i]) begin
            @(posedge ref_clk_i);
            cmd_i <= cmd_t'(ROWS[i].cmd);
            step(1);
            chk(command_parity_out_o, ROWS[i].par, "command parity");
        end
        @(posedge ref_clk_i);
        cmd_i <= '0;
        reg_read(CTRL_OFS, d);
        chk(d, 32'h00000800, "ctrl reset value");
        reg_write(STATUS_OFS, 32'hffffffff);
        reg_read(STATUS_OFS, d);
        chk(d, 32'h00000002, "status after write");
        reg_write(CTRL_OFS, 32'hffffffff);
        reg_read(CTRL_OFS, d);
        chk(d, 32'h00000fff, "ctrl width");
        reg_read(4'h8, d);
        chk(d, 32'h00000000, "unmapped read");
        reg_write(CTRL_OFS, 32'h00000800);
        // a read without calibration must not produce data
        rd_burst(hits, d);
        chk(hits, 0, "uncalibrated reads");
        reg_write(CTRL_OFS, 32'h00000c01);
        rd_burst(hits, d);
        chk(hits, 1, "read words per burst");
        chk(d, 32'h3ca53ca5, "read data");
        reg_write(CTRL_OFS, 32'h00000e01);
        rd_burst(hits, d);
        chk(hits, 2, "aligned read words");
        reg_write(CTRL_OFS, 32'h00000d01);
        rd_burst(hits, d);
        chk(hits, 2, "late realign words");
        chk(d, 32'h3ca53ca5, "late realign data");
        @(posedge ref_clk_i);
        inject <= 1'b1;
        @(posedge ref_clk_i);
        inject <= 1'b0;
        step(3);
        chk(parity_fault_n_o, 1'b0, "parity fault set");
        step(20);
        chk(parity_fault_n_o, 1'b0, "parity fault held");
        reg_read(STATUS_OFS, d);
        chk(d[0], 1'b1, "status fault bit");
        @(posedge ref_clk_i);
        soft_reset_n_i <= 1'b0;
        step(4);
        chk({mem_clk_oe_o, pll_reset_o, mem_reset_n_o}, 3'b100, "soft reset");
        @(posedge ref_clk_i);
        soft_reset_n_i <= 1'b1;
        step(2);
        wait_core();
        chk(parity_fault_n_o, 1'b1, "fault cleared");
        @(posedge ref_clk_i);
        pll_locked_i <= 1'b0;
        step(4);
        chk({reset_request_n_o, mem_reset_n_o}, 2'b00, "lock loss");
        chk(req_falls, 1, "request falling edges");
        @(posedge ref_clk_i);
        pll_locked_i <= 1'b1;
        wait_core();
        reg_write(CTRL_OFS, 32'h00000c01);
        @(posedge ref_clk_i);
        global_reset_n_i <= 1'b0;
        step(3);
        chk({pll_reset_o, mem_clk_oe_o, core_reset_n_o}, 3'b100, "global reset");
        @(posedge ref_clk_i);
        global_reset_n_i <= 1'b1;
        wait_core();
        reg_read(CTRL_OFS, d);
        chk(d, 32'h00000800, "ctrl after global reset");
        chk(mem_clk_oe_o, 1'b1, "divider restarted");
        close_out();
    end
endmodule : tb

bind ddr3_phy_read_path_reset ddr3_phy_chk u_chk (.ref_clk_i, .rst_i, .global_reset_n_i,
    .soft_reset_n_i, .pll_locked_i, .pll_reset_o, .reset_request_n_o, .core_reset_n_o,
    .mem_reset_n_o, .half_rate_en_o, .drift_tracking_clock_o, .mem_clk_o, .mem_clk_n_o,
    .mem_clk_oe_o, .cmd_i, .command_parity_out_o, .mem_err_out_n_i, .parity_fault_n_o,
    .postamble_gate_o);
